// ===== logic/pdc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz mclk, Avalon-MM word addressing by byte address
// Notes:   offsets are byte addresses of 32-bit words
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

`define PDC_CLK_MHZ            100
`define PDC_PERIOD_US          100
`define PDC_PERIOD_CYC         (`PDC_PERIOD_US * `PDC_CLK_MHZ)
`define PDC_CONV_CYC_DEF       32

`define PDC_OFF_TIMER_START    8'h00
`define PDC_OFF_CONV_CTRL0     8'h04
`define PDC_OFF_RESULT0        8'h08
`define PDC_OFF_CONV_IRQ_CTRL  8'h0C
`define PDC_OFF_IRQ_STATUS     8'h10
`define PDC_OFF_IRQ_MASK       8'h14
`define PDC_OFF_DMA_CTRL       8'h18
`define PDC_OFF_DMA_COUNT      8'h1C
`define PDC_OFF_BUF_BASE       8'h40

`define PDC_BIT_TIMER0_START   0
`define PDC_BIT_CONV_START     0
`define PDC_BIT_IRQ_REQ        0
`define PDC_BIT_DMA_EN         0
`define PDC_BIT_EV_TIMER       0
`define PDC_BIT_EV_CONV        1
`define PDC_BIT_EV_WRAP        2

`define PDC_RST_DMA_COUNT      5'h10
`define PDC_BUF_DEPTH          16

`endif

// ===== logic/pdc_pkg.sv
// Purpose: shared types for the periodic capture block
// Assumes: nothing beyond SystemVerilog packages
// Notes:   constants live in pdc_defines.svh
package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_CONV_IDLE,
    PDC_CONV_BUSY,
    PDC_CONV_DMA
  } pdc_conv_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        read;
    logic        write;
    logic [31:0] wdata;
  } pdc_bus_req_t;

  typedef struct packed {
    logic [2:0] timer;
    logic [2:0] unused;
  } pdc_pad_t;

endpackage : pdc_pkg

// ===== logic/pdc_capture.sv
// Purpose: periodic timer, one-shot converter control and repeat dma into a ring
// Assumes: converter data arrives as a sampled bus from the analog front end
// Notes:   single clock mclk, avalon-mm slave with waitrequest
//
// What this block does
// RL1 - Writing 1 to the timer0 count-start bit starts the periodic timer.
// RL2 - The running timer raises its request every 100 us.
// RL3 - Software sets the conversion-start bit once per timer request.
// RL4 - The converter does one conversion per start and then stops.
// RL5 - Only analog input channel 0 is sampled.
// RL6 - On completion the value is loaded into the channel 0 result register.
// RL7 - On completion the conversion-start bit clears itself.
// RL8 - On completion the interrupt request flag is set.
// RL9 - The completion request triggers a dma move of the result into the buffer.
// RL10 - The dma runs in repeat mode, reusing the same buffer.
// RL11 - The buffer holds 16 results; the repeat count resets to 16 and can be set from 1 to 16, with writes whose bits 4:0 are 0 or above 16 clipped to 16.
// RL12 - After the last entry the dma reloads to entry 0 and keeps running.
// RL13 - Each entry is a 16-bit halfword and each transfer writes one result.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_capture #(
  parameter int          RES_W    = 16,
  parameter int          DEPTH    = `PDC_BUF_DEPTH,
  parameter int unsigned PERIOD   = `PDC_PERIOD_CYC,
  parameter int unsigned CONV_CYC = `PDC_CONV_CYC_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // analog front end, channel 0 only
  input  wire logic [RES_W-1:0]  analog_input_channel0,
  output logic                   sample_hold,
  // interrupt
  output logic                   irq
);

  localparam int AW = $clog2(DEPTH);

  // bus request grouped
  pdc_pkg::pdc_bus_req_t req;
  assign req = '{addr: avs_address, read: avs_read, write: avs_write,
                 wdata: avs_writedata};

  logic                    ack_q;
  logic                    wr_acc;
  logic                    rd_acc;
  logic                    timer0_count_start_bit_q;
  logic                    conversion_start_bit_q;
  logic                    interrupt_request_flag_q;
  logic [RES_W-1:0]        channel0_result_register_q;
  logic [2:0]              irq_status_q;
  logic [2:0]              irq_mask_q;
  logic                    dma_en_q;
  logic [4:0]              dma_count_q;
  logic [AW-1:0]           dma_ptr_q;
  logic [31:0]             tmr_q;
  logic [31:0]             conv_cnt_q;
  logic                    tmr_tick;
  logic                    conv_done;
  logic                    dma_xfer;
  logic                    dma_wrap;
  logic [RES_W-1:0]        ain_s1_q;
  logic [RES_W-1:0]        ain_s2_q;
  logic [RES_W-1:0]        ad_buf [DEPTH];
  pdc_pkg::pdc_conv_state_t state_q;

  // register hit check, used by both bus directions
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // one wait state: ack on the second cycle of each request
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= (req.read | req.write) & ~ack_q;
  end

  assign avs_waitrequest = (req.read | req.write) & ~ack_q;
  assign wr_acc          = req.write & ack_q;
  assign rd_acc          = req.read & ack_q;

  // input synchroniser, the analog value comes from outside the clock
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ain_s1_q <= '0;
      ain_s2_q <= '0;
    end
    else
    begin
      ain_s1_q <= analog_input_channel0;
      ain_s2_q <= ain_s1_q;
    end
  end

  // timer run bit
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      timer0_count_start_bit_q <= 1'b0;
    // RL1 start on write
    else if (wr_acc && hit(req.addr, `PDC_OFF_TIMER_START))
      timer0_count_start_bit_q <= req.wdata[`PDC_BIT_TIMER0_START];
  end

  // periodic counter; restarts from zero on each start
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tmr_q <= 32'h0;
    else if (!timer0_count_start_bit_q)
      tmr_q <= 32'h0;
    // RL2 100 us period
    else if (tmr_q == PERIOD - 1)
      tmr_q <= 32'h0;
    else
      tmr_q <= tmr_q + 32'h1;
  end

  assign tmr_tick = timer0_count_start_bit_q && (tmr_q == PERIOD - 1);

  // converter sequencer; starts only from idle so one start gives one result
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q    <= pdc_pkg::PDC_CONV_IDLE;
      conv_cnt_q <= 32'h0;
    end
    else
    begin
      unique case (state_q)
        pdc_pkg::PDC_CONV_IDLE:
        begin
          conv_cnt_q <= 32'h0;
          // RL4 one-shot start
          if (conversion_start_bit_q)
            state_q <= pdc_pkg::PDC_CONV_BUSY;
        end
        pdc_pkg::PDC_CONV_BUSY:
        begin
          conv_cnt_q <= conv_cnt_q + 32'h1;
          if (conv_done)
            state_q <= dma_en_q ? pdc_pkg::PDC_CONV_DMA : pdc_pkg::PDC_CONV_IDLE;
        end
        pdc_pkg::PDC_CONV_DMA:
          state_q <= pdc_pkg::PDC_CONV_IDLE;
      endcase
    end
  end

  assign conv_done   = (state_q == pdc_pkg::PDC_CONV_BUSY) && (conv_cnt_q == CONV_CYC - 1);
  assign sample_hold = (state_q == pdc_pkg::PDC_CONV_BUSY);

  // start bit: software sets, hardware clears at completion
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      conversion_start_bit_q <= 1'b0;
    // RL7 self clear
    else if (conv_done)
      conversion_start_bit_q <= 1'b0;
    else if (wr_acc && hit(req.addr, `PDC_OFF_CONV_CTRL0))
      conversion_start_bit_q <= req.wdata[`PDC_BIT_CONV_START];
  end

  // result register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      channel0_result_register_q <= '0;
    // RL5 channel 0 only
    // RL6 load result
    else if (conv_done)
      channel0_result_register_q <= ain_s2_q;
  end

  // request flag; set beats a software clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      interrupt_request_flag_q <= 1'b0;
    // RL8 flag set
    else if (conv_done)
      interrupt_request_flag_q <= 1'b1;
    // dma consumes the request, as a serviced request would
    else if (dma_xfer)
      interrupt_request_flag_q <= 1'b0;
    else if (wr_acc && hit(req.addr, `PDC_OFF_CONV_IRQ_CTRL))
      interrupt_request_flag_q <= req.wdata[`PDC_BIT_IRQ_REQ];
  end

  // dma config
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dma_en_q    <= 1'b0;
      dma_count_q <= `PDC_RST_DMA_COUNT;
    end
    else if (wr_acc && hit(req.addr, `PDC_OFF_DMA_CTRL))
      dma_en_q <= req.wdata[`PDC_BIT_DMA_EN];
    // RL11 repeat count, clipped to buffer size
    else if (wr_acc && hit(req.addr, `PDC_OFF_DMA_COUNT))
      dma_count_q <= (req.wdata[4:0] == 5'h0 || req.wdata[4:0] > 5'(DEPTH))
                     ? 5'(DEPTH) : req.wdata[4:0];
  end

  // RL9 transfer trigger, one cycle after completion
  assign dma_xfer = (state_q == pdc_pkg::PDC_CONV_DMA) && interrupt_request_flag_q;
  assign dma_wrap = dma_xfer && ({1'b0, dma_ptr_q} == 5'(dma_count_q - 5'h1));

  // destination pointer
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      dma_ptr_q <= '0;
    // RL10 repeat mode
    // RL12 reload to entry 0
    else if (dma_wrap)
      dma_ptr_q <= '0;
    else if (dma_xfer)
      dma_ptr_q <= dma_ptr_q + AW'(1);
  end

  // RL13 one halfword per transfer
  always_ff @(posedge mclk)
  begin
    if (dma_xfer)
      ad_buf[dma_ptr_q] <= channel0_result_register_q;
  end

  // sticky events; set wins over write-one-to-clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_status_q <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if ((i == `PDC_BIT_EV_TIMER && tmr_tick) || (i == `PDC_BIT_EV_CONV && conv_done)
            || (i == `PDC_BIT_EV_WRAP && dma_wrap))
          irq_status_q[i] <= 1'b1;
        else if (wr_acc && hit(req.addr, `PDC_OFF_IRQ_STATUS) && req.wdata[i])
          irq_status_q[i] <= 1'b0;
      end
    end
  end

  // mask register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_mask_q <= 3'h0;
    else if (wr_acc && hit(req.addr, `PDC_OFF_IRQ_MASK))
      irq_mask_q <= req.wdata[2:0];
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_status_q & irq_mask_q);
  end

  // read data registered in the wait cycle, ready at the ack; unmapped reads return zero
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0;
    else if ((req.read) && !ack_q)
    begin
      avs_readdata <= 32'h0;
      if (hit(req.addr, `PDC_OFF_TIMER_START))
        avs_readdata[0] <= timer0_count_start_bit_q;
      else if (hit(req.addr, `PDC_OFF_CONV_CTRL0))
        avs_readdata[0] <= conversion_start_bit_q;
      else if (hit(req.addr, `PDC_OFF_RESULT0))
        avs_readdata[RES_W-1:0] <= channel0_result_register_q;
      else if (hit(req.addr, `PDC_OFF_CONV_IRQ_CTRL))
        avs_readdata[0] <= interrupt_request_flag_q;
      else if (hit(req.addr, `PDC_OFF_IRQ_STATUS))
        avs_readdata[2:0] <= irq_status_q;
      else if (hit(req.addr, `PDC_OFF_IRQ_MASK))
        avs_readdata[2:0] <= irq_mask_q;
      else if (hit(req.addr, `PDC_OFF_DMA_CTRL))
        avs_readdata[AW+15:0] <= {dma_ptr_q, 15'h0, dma_en_q};
      else if (hit(req.addr, `PDC_OFF_DMA_COUNT))
        avs_readdata[4:0] <= dma_count_q;
      else if (req.addr >= `PDC_OFF_BUF_BASE
               && req.addr < 8'(`PDC_OFF_BUF_BASE + 4 * DEPTH))
        avs_readdata[RES_W-1:0] <= ad_buf[req.addr[AW+1:2]];
    end
  end

endmodule : pdc_capture
`default_nettype wire

// ===== testbench/pdc_analog_src.sv
// Purpose: analog front end model driving channel 0
// Assumes: one sample per conversion, value steps after each one
// Notes:   value moves only while no conversion runs
`timescale 1ns/1ps
`default_nettype none
module pdc_analog_src (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // converter side
  input  wire logic        sample_hold,
  output logic [15:0]      ain
);
  logic [1:0] gap_q;
  logic       hold_q;
  // single channel source
  // step three cycles after a conversion ends so the held value stays put
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ain    <= 16'hA000;
      gap_q  <= 2'h0;
      hold_q <= 1'b0;
    end
    else
    begin
      hold_q <= sample_hold;
      if (hold_q && !sample_hold) gap_q <= 2'h2;
      else if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
      if (gap_q == 2'h1) ain <= ain + 16'h0001;
    end
  end
endmodule : pdc_analog_src
`default_nettype wire

// ===== testbench/pdc_capture_chk.sv
// Purpose: port level checks of the capture block
// Assumes: master releases the bus for a cycle after each ack
// Notes:   mask is tracked from acked writes
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_capture_chk #(
  parameter int unsigned CONV_CYC = `PDC_CONV_CYC_DEF
) (
  // bus
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // converter and interrupt
  input  wire logic        sample_hold,
  input  wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [15:0] len_q;
  logic [2:0]  mask_q;
  logic        wr_ack;
  // acked write strobe
  assign wr_ack = avs_write && !avs_waitrequest;
  // conversion length and mask shadow
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      len_q  <= 16'h0000;
      mask_q <= 3'h0;
    end
    else
    begin
      len_q <= sample_hold ? len_q + 16'h0001 : 16'h0000;
      if (wr_ack && avs_address == `PDC_OFF_IRQ_MASK) mask_q <= avs_writedata[2:0];
    end
  end
  sequence s_start;
    wr_ack && avs_address == `PDC_OFF_CONV_CTRL0 && avs_writedata[0];
  endsequence
  a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait state on new request");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_start_conv: assert property (s_start ##0 !sample_hold |-> ##[1:3] sample_hold)
    else $error("start did not launch a conversion");
  a_conv_len: assert property ($fell(sample_hold) |-> len_q == CONV_CYC)
    else $error("conversion length wrong");
  a_one_shot: assert property ($fell(sample_hold) |=> !sample_hold [*3])
    else $error("converter restarted on its own");
  a_irq_done: assert property ($fell(sample_hold) && mask_q[1] |-> ##[0:3] irq)
    else $error("no interrupt after conversion");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule : pdc_capture_chk
`default_nettype wire

// ===== testbench/pdc_capture_tb.sv
// Purpose: register level tests of the capture block
// Assumes: short period and conversion parameters
// Notes:   expected samples follow the front end model steps
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_capture_tb;
  localparam int PER = 50;
  logic        mclk = 1'b0, sys_rst = 1'b1, rd = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic        wrq, sh, irq;
  logic [15:0] ain;
  int          bad_count = 0, check_count = 0, cyc = 0, t0, n;
  always #5 mclk = ~mclk;
  pdc_capture #(.PERIOD(PER), .CONV_CYC(4)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(adr), .avs_read(rd), .avs_write(we), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wrq), .analog_input_channel0(ain),
    .sample_hold(sh), .irq(irq));
  pdc_analog_src SRC (.mclk(mclk), .sys_rst(sys_rst), .sample_hold(sh), .ain(ain));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // one avalon cycle, held until waitrequest is seen low
  // no cycle limit here: only the bench timeout ends a stuck wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    we  <= w;
    do
    begin
      @(posedge mclk);
    end
    while (wrq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, v);
      bad_count++;
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rdc
  // wait for a fresh rise; irq is registered, so an old level lingers a cycle
  task automatic wirq;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (irq !== 1'b0 && n < 200);
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (irq !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      $display("wrong value irq rise expected 1 seen %b", irq);
      bad_count++;
    end
  endtask : wirq
  // run one conversion and wait for the start bit to drop
  task automatic conv;
    bus(1'b1, `PDC_OFF_CONV_CTRL0, 32'h1);
    n = 0;
    do begin bus(1'b0, `PDC_OFF_CONV_CTRL0, 32'h0); n++; end while (q[0] !== 1'b0 && n < 20);
    chk("start bit", 32'h0, {31'h0, q[0]});
  endtask : conv
  // non-blocking so readers at the same edge all see the old count
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdc("repeat count", `PDC_OFF_DMA_COUNT, 32'h10);
    rdc("unmapped", 8'h30, 32'h0);
    rdc("start reset", `PDC_OFF_CONV_CTRL0, 32'h0);
    // periodic tick spacing
    bus(1'b1, `PDC_OFF_IRQ_MASK, 32'h1);
    bus(1'b1, `PDC_OFF_TIMER_START, 32'h1);
    wirq();
    t0 = cyc;
    bus(1'b1, `PDC_OFF_IRQ_STATUS, 32'h1);
    wirq();
    chk("tick period", PER, cyc - t0);
    bus(1'b1, `PDC_OFF_TIMER_START, 32'h0);
    bus(1'b1, `PDC_OFF_IRQ_MASK, 32'h2);
    bus(1'b1, `PDC_OFF_IRQ_STATUS, 32'h7);
    $display("test timer done");
    // one-shot with the transfer engine off
    conv();
    rdc("result", `PDC_OFF_RESULT0, 32'hA000);
    rdc("request flag", `PDC_OFF_CONV_IRQ_CTRL, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, `PDC_OFF_IRQ_STATUS, 32'h2);
    bus(1'b1, `PDC_OFF_CONV_IRQ_CTRL, 32'h0);
    $display("test single done");
    // eighteen transfers wrap a sixteen entry ring
    bus(1'b1, `PDC_OFF_DMA_COUNT, 32'h1F);
    rdc("count clip", `PDC_OFF_DMA_COUNT, 32'h10);
    bus(1'b1, `PDC_OFF_DMA_COUNT, 32'h10);
    bus(1'b1, `PDC_OFF_DMA_CTRL, 32'h1);
    for (int k = 1; k <= 18; k++) conv();
    rdc("flag cleared", `PDC_OFF_CONV_IRQ_CTRL, 32'h0);
    rdc("status", `PDC_OFF_IRQ_STATUS, 32'h6);
    for (int i = 0; i < 16; i++)
      rdc("entry", `PDC_OFF_BUF_BASE + 8'(4 * i), 32'hA000 + (i < 2 ? 17 + i : 1 + i));
    bus(1'b0, `PDC_OFF_DMA_CTRL, 32'h0);
    chk("pointer", 32'h2, {28'h0, q[19:16]});
    $display("test ring done");
    end_sim();
  end
endmodule : pdc_capture_tb
bind pdc_capture pdc_capture_chk #(.CONV_CYC(CONV_CYC)) CHK (.mclk(mclk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_hold(sample_hold), .irq(irq));
`default_nettype wire
